// file: rtl/rcoc_pkg.sv
// Shared constants for the reference clock output control block
package rcoc_pkg;
  // Clock rates in MHz; the half-period tick rate is twice the reference
  localparam int SYS_CLK_MHZ = 125;
  localparam int REF_CLK_MHZ = 16;
  localparam logic [7:0] NCO_MOD = 8'(SYS_CLK_MHZ);
  localparam logic [7:0] NCO_INC = 8'(2 * REF_CLK_MHZ);
  localparam logic [7:0] NCO_INC_LO = NCO_INC - 8'h01;
  localparam logic [7:0] NCO_INC_HI = NCO_INC + 8'h01;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_PAD_CTRL = 6'h03;
  localparam logic [5:0] IDX_RX_CTRL = 6'h0A;
  localparam logic [5:0] IDX_MOD_CTRL = 6'h0C;
  localparam logic [5:0] IDX_OSC_CTRL = 6'h12;
  localparam logic [5:0] IDX_STATUS = 6'h20;

  // Reset values
  localparam logic [7:0] RST_PAD_CTRL = 8'h19;
  localparam logic [7:0] RST_RX_CTRL = 8'h17;
  localparam logic [7:0] RST_MOD_CTRL = 8'h04;
  localparam logic [7:0] RST_OSC_CTRL = 8'hF0;
  localparam logic [2:0] RATE_RESET = 3'h1;

  // Field positions
  localparam int POS_DEFER = 3;
  localparam int POS_DRIVE = 4;
  localparam int POS_JITTER = 5;
  localparam int POS_SUBMODE = 2;
  localparam int POS_BPSK = 3;
  localparam int POS_OSC_SRC = 4;

  // Rate codes and the external oscillator source code
  localparam logic [2:0] RATE_OFF = 3'h0;
  localparam logic [2:0] RATE_16M = 3'h5;
  localparam logic [2:0] RATE_250K = 3'h6;
  localparam logic [2:0] RATE_SYM = 3'h7;
  localparam logic [3:0] OSC_EXTERNAL = 4'h4;

  // Output cycles delivered before sleep at rate codes 1 to 5; other codes sleep at once
  localparam logic [5:0] DRAIN_CYCLES = 6'd35;

  // Symbol-rate half periods in 32 MHz half ticks (20k, 40k, 25k, 62.5k)
  localparam logic [9:0] SYM_HALF_20K = 10'd800;
  localparam logic [9:0] SYM_HALF_40K = 10'd400;
  localparam logic [9:0] SYM_HALF_25K = 10'd640;
  localparam logic [9:0] SYM_HALF_62K5 = 10'd256;

  localparam logic [15:0] LFSR_SEED = 16'hACE1;

  typedef enum logic [1:0] {ST_RUN, ST_DRAIN, ST_SLEEP} rcoc_state_t;
endpackage

// file: rtl/rcoc_divider.sv
// Prescaler: raw reference half ticks, binary taps, symbol clock, jitter
`timescale 1ns/1ns
module rcoc_divider
  import rcoc_pkg::*;
(
  input wire logic refClk,
  input wire logic rstN,
  input wire logic jitterOn,
  input wire logic [9:0] symHalf,
  output logic [6:0] divCnt,
  output logic symClk
);
  logic [7:0] acc_r, acc_nxt;
  logic [6:0] cnt_r, cnt_nxt;
  logic [9:0] symCnt_r, symCnt_nxt;
  logic sym_r, sym_nxt;
  logic [15:0] lfsr_r, lfsr_nxt;
  logic [8:0] sum;
  logic [7:0] inc;
  logic tick;

  always_comb begin
    // Jitter widens/narrows half periods; average rate stays at the reference
    inc = NCO_INC;
    if (jitterOn) begin
      inc = lfsr_r[0] ? NCO_INC_HI : NCO_INC_LO;
    end
    sum = {1'b0, acc_r} + {1'b0, inc};
    tick = (sum >= {1'b0, NCO_MOD});
    acc_nxt = tick ? 8'(sum - {1'b0, NCO_MOD}) : sum[7:0];
    lfsr_nxt = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    cnt_nxt = cnt_r;
    symCnt_nxt = symCnt_r;
    sym_nxt = sym_r;
    if (tick) begin
      cnt_nxt = cnt_r + 7'h01;
      if (symCnt_r >= symHalf - 10'h001) begin
        symCnt_nxt = '0;
        sym_nxt = ~sym_r;
      end else begin
        symCnt_nxt = symCnt_r + 10'h001;
      end
    end
  end

  always_ff @(posedge refClk or negedge rstN) begin
    if (!rstN) begin
      acc_r <= '0;
      cnt_r <= '0;
      symCnt_r <= '0;
      sym_r <= 1'b0;
      lfsr_r <= LFSR_SEED;
    end else begin
      acc_r <= acc_nxt;
      cnt_r <= cnt_nxt;
      symCnt_r <= symCnt_nxt;
      sym_r <= sym_nxt;
      lfsr_r <= lfsr_nxt;
    end
  end

  assign divCnt = cnt_r;
  assign symClk = sym_r;
endmodule

// file: rtl/rcoc_clock_out.sv
// Reference clock output control with Wishbone register access
//
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
module rcoc_clock_out
  import rcoc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic powerOnReset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sleep_request_pin,
  input wire logic radio_off_state,
  input wire logic txActive,
  input wire logic filterTuning,
  output logic clock_out_pin,
  output logic [1:0] clockOutDrive,
  output logic [1:0] padDrive,
  output logic jitterActive,
  output logic oscPowerDown,
  output logic [3:0] osc_load_trim,
  output logic sleeping
);
  logic rstMeta_r, rstSync_r, porMeta_r, porSync_r, devRstN, porRstN;

  // Device reset and power-on reset, each released through two flops
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  always_ff @(posedge ref_clk or negedge powerOnReset_n) begin
    if (!powerOnReset_n) begin
      porMeta_r <= 1'b0;
      porSync_r <= 1'b0;
    end else begin
      porMeta_r <= 1'b1;
      porSync_r <= porMeta_r;
    end
  end

  assign devRstN = rstSync_r;
  assign porRstN = porSync_r;

  // Output level of a rate code, given the prescaler state
  function automatic logic rateTap(input logic [2:0] code, input logic [6:0] cnt,
                                   input logic sym);
    unique case (code)
      RATE_OFF: rateTap = 1'b0;
      3'h1: rateTap = cnt[4];
      3'h2: rateTap = cnt[3];
      3'h3: rateTap = cnt[2];
      3'h4: rateTap = cnt[1];
      RATE_16M: rateTap = cnt[0];
      RATE_250K: rateTap = cnt[6];
      RATE_SYM: rateTap = sym;
    endcase
  endfunction

  // Register file
  logic [7:0] padCtrl_r, padCtrl_nxt, rxCtrl_r, rxCtrl_nxt;
  logic [7:0] modCtrl_r, modCtrl_nxt, oscCtrl_r, oscCtrl_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic immReq_r, immReq_nxt;
  logic [2:0] effRate_r, effRate_nxt;
  rcoc_state_t state_r, state_nxt;
  logic [5:0] drain_r, drain_nxt;
  logic outLvl_r, outLvl_nxt;
  logic [6:0] divCnt;
  logic symClk;
  logic [9:0] symHalf;
  logic [5:0] idx;
  logic wrStrobe, wrPad, curTap, newTap, fallEdge;
  logic [7:0] statusVal;

  assign idx = wb_adr_i[7:2];
  assign wrStrobe = wb_cyc_i && wb_stb_i && ack_r && wb_we_i && wb_sel_i[0];
  assign wrPad = wrStrobe && (idx == IDX_PAD_CTRL);

  always_comb begin
    statusVal = {1'b0, effRate_r, (padCtrl_r[2:0] != effRate_r),
                 jitterActive, (state_r == ST_DRAIN), (state_r == ST_SLEEP)};
    ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
    dat_nxt = dat_r;
    if (ack_nxt) begin
      // Unmapped indices read as zero
      unique case (idx)
        IDX_PAD_CTRL: dat_nxt = {24'h0, padCtrl_r};
        IDX_RX_CTRL: dat_nxt = {24'h0, rxCtrl_r};
        IDX_MOD_CTRL: dat_nxt = {24'h0, modCtrl_r};
        IDX_OSC_CTRL: dat_nxt = {24'h0, oscCtrl_r};
        IDX_STATUS: dat_nxt = {24'h0, statusVal};
        default: dat_nxt = 32'h0;
      endcase
    end
    padCtrl_nxt = padCtrl_r;
    rxCtrl_nxt = rxCtrl_r;
    modCtrl_nxt = modCtrl_r;
    oscCtrl_nxt = oscCtrl_r;
    if (wrStrobe) begin
      unique case (idx)
        IDX_PAD_CTRL: padCtrl_nxt = wb_dat_i[7:0];
        IDX_RX_CTRL: rxCtrl_nxt = wb_dat_i[7:0];
        IDX_MOD_CTRL: modCtrl_nxt = {4'h0, wb_dat_i[3:2], 2'h0};
        IDX_OSC_CTRL: oscCtrl_nxt = wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  // Rate field and defer bit reset with the device; effective rate does not
  always_ff @(posedge ref_clk or negedge devRstN) begin
    if (!devRstN) begin
      padCtrl_r <= RST_PAD_CTRL;
      rxCtrl_r <= RST_RX_CTRL;
      modCtrl_r <= RST_MOD_CTRL;
      oscCtrl_r <= RST_OSC_CTRL;
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      padCtrl_r <= padCtrl_nxt;
      rxCtrl_r <= rxCtrl_nxt;
      modCtrl_r <= modCtrl_nxt;
      oscCtrl_r <= oscCtrl_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // Symbol clock half period follows the active modulation
  always_comb begin
    unique case ({modCtrl_r[POS_BPSK], modCtrl_r[POS_SUBMODE]})
      2'b00: symHalf = SYM_HALF_20K;
      2'b01: symHalf = SYM_HALF_40K;
      2'b10: symHalf = SYM_HALF_25K;
      2'b11: symHalf = SYM_HALF_62K5;
    endcase
  end

  // Jitter gated off while transmitting or tuning; transmit path has its own clock
  assign jitterActive = rxCtrl_r[POS_JITTER] && !txActive && !filterTuning;

  // Prescaler keeps running through device reset so the pin never stalls
  rcoc_divider u_div (
    .refClk(ref_clk),
    .rstN(porRstN),
    .jitterOn(jitterActive),
    .symHalf(symHalf),
    .divCnt(divCnt),
    .symClk(symClk)
  );

  assign curTap = rateTap(effRate_r, divCnt, symClk);
  assign newTap = rateTap(padCtrl_r[2:0], divCnt, symClk);
  assign fallEdge = outLvl_r && !curTap;

  // Rate sequencing and sleep handling
  always_comb begin
    immReq_nxt = immReq_r;
    effRate_nxt = effRate_r;
    state_nxt = state_r;
    drain_nxt = drain_r;
    outLvl_nxt = (state_r == ST_SLEEP) ? 1'b0 : curTap;
    if (wrPad && (!wb_dat_i[POS_DEFER] || effRate_r == RATE_OFF)) begin
      immReq_nxt = 1'b1;
    end
    unique case (state_r)
      ST_RUN: begin
        // Switch only while old and new clocks are both low
        if (immReq_r && !outLvl_r && !curTap && !newTap) begin
          effRate_nxt = padCtrl_r[2:0];
          immReq_nxt = wrPad && (!wb_dat_i[POS_DEFER] || padCtrl_r[2:0] == RATE_OFF);
        end
        if (sleep_request_pin && radio_off_state) begin
          if (effRate_r != RATE_OFF && effRate_r <= RATE_16M) begin
            state_nxt = ST_DRAIN;
            drain_nxt = '0;
          end else begin
            state_nxt = ST_SLEEP;
          end
        end
      end
      ST_DRAIN: begin
        if (fallEdge) begin
          drain_nxt = drain_r + 6'h01;
          if (drain_r == DRAIN_CYCLES - 6'h01) begin
            state_nxt = ST_SLEEP;
          end
        end
      end
      ST_SLEEP: begin
        if (!sleep_request_pin) begin
          // Stored rate (possibly the reset value) takes over on wake
          effRate_nxt = padCtrl_r[2:0];
          // A rate write landing in the wake cycle keeps its immediate request
          immReq_nxt = wrPad && (!wb_dat_i[POS_DEFER] || padCtrl_r[2:0] == RATE_OFF);
          state_nxt = ST_RUN;
        end
      end
    endcase
  end

  // Effective rate and sleep state survive device reset: only power-on clears them
  always_ff @(posedge ref_clk or negedge porRstN) begin
    if (!porRstN) begin
      effRate_r <= RATE_RESET;
      immReq_r <= 1'b0;
      state_r <= ST_RUN;
      drain_r <= '0;
      outLvl_r <= 1'b0;
    end else begin
      effRate_r <= effRate_nxt;
      immReq_r <= immReq_nxt;
      state_r <= state_nxt;
      drain_r <= drain_nxt;
      outLvl_r <= outLvl_nxt;
    end
  end

  assign clock_out_pin = outLvl_r;
  assign clockOutDrive = padCtrl_r[POS_DRIVE+1:POS_DRIVE];
  assign padDrive = padCtrl_r[7:6];
  assign oscPowerDown = (oscCtrl_r[7:POS_OSC_SRC] == OSC_EXTERNAL);
  assign osc_load_trim = oscCtrl_r[3:0];
  assign sleeping = (state_r == ST_SLEEP);
endmodule

// file: tb/rcoc_clock_out_assertions.sv
// Port-level checks for the reference clock output control block
`timescale 1ns/1ns
module rcoc_clock_out_assertions (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic powerOnReset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic sleep_request_pin,
  input wire logic txActive,
  input wire logic filterTuning,
  input wire logic clock_out_pin,
  input wire logic [1:0] clockOutDrive,
  input wire logic [1:0] padDrive,
  input wire logic jitterActive,
  input wire logic oscPowerDown,
  input wire logic [3:0] osc_load_trim,
  input wire logic sleeping
);
  logic wrOk;
  assign wrOk = wb_ack_o && wb_we_i && wb_sel_i[0];
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n || !powerOnReset_n);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held beyond one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered after one cycle");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h10 |-> wb_dat_o == '0)
    else $error("unmapped read not zero");
  a_jitter_forced: assert property (txActive || filterTuning |-> !jitterActive)
    else $error("jitter active during transmit or tuning");
  a_sleep_quiet: assert property (sleeping && $past(sleeping) |-> !clock_out_pin)
    else $error("clock output toggles in sleep");
  a_wake_prompt: assert property (sleeping && !sleep_request_pin |-> ##[1:2] !sleeping)
    else $error("no wake after request drop");
  a_src_write: assert property (wrOk && wb_adr_i == 8'h48 |=>
    oscPowerDown == ((($past(wb_dat_i) >> 4) & 32'h0000000F) == 32'h4))
    else $error("oscillator power down mismatch");
  a_trim_write: assert property (wrOk && wb_adr_i == 8'h48 |=>
    osc_load_trim == 4'($past(wb_dat_i)))
    else $error("load trim mismatch");
  a_drive_write: assert property (wrOk && wb_adr_i == 8'h0C |=>
    clockOutDrive == 2'($past(wb_dat_i) >> 4) && padDrive == 2'($past(wb_dat_i) >> 6))
    else $error("drive strength mismatch");
endmodule
bind rcoc_clock_out rcoc_clock_out_assertions chk (.*);

// file: tb/rcoc_host_model.sv
// Host side sampling the clock output pin on the reference clock: counts edges, keeps shortest high phase
`timescale 1ns/1ns
module rcoc_host_model (
  input wire logic refClk,
  input wire logic clkIn,
  output int rises,
  output int falls,
  output int minHigh
);
  logic last = 1'b0;
  int hiLen = 0;
  int riseCnt = 0;
  int fallCnt = 0;
  int minHi = 1000;
  // Pin is sampled with the reference clock, so one count per real edge
  always @(posedge refClk) begin
    if (clkIn && !last) riseCnt++;
    hiLen = clkIn ? hiLen + 1 : hiLen;
    if (!clkIn && last) begin
      fallCnt++;
      if (hiLen < minHi) minHi = hiLen;
      hiLen = 0;
    end
    last = clkIn;
  end
  assign rises = riseCnt;
  assign falls = fallCnt;
  assign minHigh = minHi;
endmodule

// file: tb/test_reference_clock_output_control.sv
// Self-checking bench for the reference clock output control block
`timescale 1ns/1ns
module test_reference_clock_output_control;
  logic ref_clk = 1'b0, reset_n = 1'b0, powerOnReset_n = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic sleep_request_pin = 1'b0, radio_off_state = 1'b1, txActive = 1'b0, filterTuning = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, clock_out_pin, jitterActive, oscPowerDown, sleeping;
  logic [1:0] clockOutDrive, padDrive;
  logic [3:0] osc_load_trim;
  logic [7:0] rd;
  int rises, falls, minHigh;
  int bad_count = 0;
  int checks = 0;
  rcoc_clock_out dut (.*);
  rcoc_host_model host (.refClk(ref_clk), .clkIn(clock_out_pin), .rises(rises),
    .falls(falls), .minHigh(minHigh));
  always #4 ref_clk = ~ref_clk;
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic hang(input string nm);
    chk(nm, 32'h0, 32'h1);
    print_verdict();
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    int n;
    @(posedge ref_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (n > 50) hang("wb_ack");
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00, 4'h1);
    chk($sformatf("reg_%0h", a), rd, e);
  endtask
  // Average rate only: the prescaler edges are quantised to the system clock
  task automatic edges(input int e, input int tol);
    int r;
    repeat (300) @(posedge ref_clk);
    r = rises;
    repeat (2000) @(posedge ref_clk);
    r = rises - r;
    chk("pin_edges", (r >= e - tol && r <= e + tol) ? e : r, e);
  endtask
  task automatic nap();
    int f, n;
    sleep_request_pin <= 1'b1;
    @(negedge ref_clk);
    f = falls;
    n = 0;
    while (sleeping !== 1'b1) begin
      @(negedge ref_clk);
      if (++n > 3000) hang("sleep");
    end
    f = falls - f;
    chk("drain_falls", (f >= 34 && f <= 36) ? 35 : f, 35);
    @(posedge ref_clk) sleep_request_pin <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("awake", sleeping, 1'b0);
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    {reset_n, powerOnReset_n} <= 2'b11;
    repeat (4) @(posedge ref_clk);
    rdc(8'h0C, 8'h19);
    rdc(8'h28, 8'h17);
    rdc(8'h30, 8'h04);
    rdc(8'h48, 8'hF0);
    rdc(8'h80, 8'h10);
    wb(1'b1, 8'h10, 8'hFF, 4'h1);
    rdc(8'h10, 8'h00);
    edges(16, 1);
    for (int c = 1; c < 7; c++) begin
      wb(1'b1, 8'h0C, 8'h10 | 8'(c), 4'h1);
      edges(c < 6 ? 16 << (c - 1) : 4, 1);
    end
    wb(1'b1, 8'h0C, 8'h10, 4'h1);
    edges(0, 0);
    wb(1'b1, 8'h0C, 8'h1D, 4'h1);
    edges(256, 1);
    wb(1'b1, 8'h0C, 8'h19, 4'h1);
    edges(256, 1);
    rdc(8'h80, 8'h58);
    nap();
    edges(16, 1);
    wb(1'b1, 8'h0C, 8'h15, 4'h1);
    // Let the immediate switch land before the field is reset
    edges(256, 1);
    reset_n <= 1'b0;
    edges(256, 1);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rdc(8'h0C, 8'h19);
    rdc(8'h80, 8'h58);
    nap();
    edges(16, 1);
    wb(1'b1, 8'h28, 8'h37, 4'h1);
    @(negedge ref_clk) chk("jitter_on", jitterActive, 1'b1);
    @(posedge ref_clk) txActive <= 1'b1;
    @(negedge ref_clk) chk("jitter_tx", jitterActive, 1'b0);
    @(posedge ref_clk) {txActive, filterTuning} <= 2'b01;
    @(negedge ref_clk) chk("jitter_tune", jitterActive, 1'b0);
    @(posedge ref_clk) filterTuning <= 1'b0;
    edges(16, 1);
    chk("min_high", minHigh >= 3, 1'b1);
    wb(1'b1, 8'h30, 8'h0C, 4'h1);
    wb(1'b1, 8'h0C, 8'h17, 4'h1);
    edges(1, 1);
    wb(1'b1, 8'h48, 8'h4A, 4'h1);
    @(negedge ref_clk) chk("osc_pd", oscPowerDown, 1'b1);
    chk("trim", osc_load_trim, 4'hA);
    wb(1'b1, 8'h48, 8'hF3, 4'h0);
    rdc(8'h48, 8'h4A);
    wb(1'b1, 8'h48, 8'hF0, 4'h1);
    @(negedge ref_clk) chk("osc_run", oscPowerDown, 1'b0);
    wb(1'b1, 8'h0C, 8'hE1, 4'h1);
    @(negedge ref_clk) chk("pad_drive", padDrive, 2'h3);
    chk("clk_drive", clockOutDrive, 2'h2);
    print_verdict();
  end
  initial begin
    repeat (95000) @(posedge ref_clk);
    hang("run_time");
  end
endmodule
